// ==== pkg/lpu_pkg.sv ====
// Shared constants and types for the link power U1 entry controller
package lpu_pkg;

  // Core clock and inactivity timer granularity
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 5;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_U1_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_U2_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_IS_DN = 0;
  localparam int CTRL_U1_EN = 1;
  localparam int CTRL_ACC_EN = 2;
  localparam int CTRL_GO_U3 = 3;
  localparam int CTRL_EXIT_U3 = 4;

  // Status register fields
  localparam int STAT_LS_LO = 0;
  localparam int STAT_WAIT = 4;
  localparam int STAT_REJ_LO = 8;

  // Reset values and the all-ones timeout code that disables a timer
  localparam logic [7:0] U1_TIMEOUT_RST = 8'h00;
  localparam logic [7:0] U2_TIMEOUT_RST = 8'h00;
  localparam logic [7:0] TIMEOUT_OFF = 8'hFF;

  // Link command codes on the command port
  localparam logic [1:0] CMD_GO_U1 = 2'h0;
  localparam logic [1:0] CMD_GO_U3 = 2'h1;
  localparam logic [1:0] CMD_ACCEPT = 2'h2;
  localparam logic [1:0] CMD_REJECT = 2'h3;

  // Reported link state, ordered by depth
  localparam logic [1:0] LS_U0 = 2'h0;
  localparam logic [1:0] LS_U1 = 2'h1;
  localparam logic [1:0] LS_U2 = 2'h2;
  localparam logic [1:0] LS_U3 = 2'h3;

  typedef enum logic [2:0] {ST_U0, ST_WAIT, ST_U1, ST_U2, ST_U3, ST_EXIT} lpu_state_t;

endpackage

// ==== design/lpu_timer.sv ====
// Inactivity timer counting divider ticks up to a programmed limit
`timescale 1ns/1ps
module lpu_timer #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic tick, // Timer granularity pulse
  input wire logic restart, // Clear and hold the count
  input wire logic [CNT_W-1:0] limit, // Expiry count, zero disables
  output logic [CNT_W-1:0] count, // Current count
  output logic expired // Level, set on expiry until restart
);

  if (CNT_W < 2)
  begin : g_chk
    $error("lpu_timer: CNT_W too small");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic exp;
  } lpu_timer_st_t;

  lpu_timer_st_t q;
  lpu_timer_st_t d;

  // Count only while enabled; a zero limit never expires
  always_comb
  begin
    d = q;
    if (restart)
    begin
      d.cnt = '0;
      d.exp = 1'b0;
    end
    else if (tick && (limit != '0) && !q.exp)
    begin
      d.cnt = q.cnt + 1'b1;
      d.exp = (d.cnt == limit);
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign count = q.cnt;
  assign expired = q.exp;

endmodule

// ==== design/lpu_ctrl.sv ====
// Link power state controller with autonomous U1 entry handshake
`timescale 1ns/1ps
module lpu_ctrl (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rx_valid, // Link command received, pulse
  input wire logic [1:0] rx_cmd, // Received link command code
  output logic tx_valid, // Link command to send, pulse
  output logic [1:0] tx_cmd, // Link command code to send
  input wire logic link_activity, // Packet traffic seen this cycle
  input wire logic tx_pending, // Packet to send soon
  input wire logic u1_policy_req, // Upstream policy wants U1
  input wire logic rx_lfps, // Partner exit signalling detected
  input wire logic remote_wake, // Remote wakeup event
  input wire logic train_done, // Recovery and training complete
  output logic [1:0] link_state, // Current link state
  output logic link_u0, // Traffic allowed
  output logic pll_off, // Clock generation may stop
  output logic lfps_req // Drive exit signalling
);

  typedef struct packed {
    lpu_pkg::lpu_state_t st;
    logic wait_u3;
    logic is_dn;
    logic u1_en;
    logic acc_en;
    logic u3_req;
    logic u3_exit;
    logic [7:0] u1_to;
    logic [7:0] u2_to;
    logic [7:0] rej_cnt;
    logic [lpu_pkg::DIV_W-1:0] div;
    logic tick;
    logic tx_valid;
    logic [1:0] tx_cmd;
    logic [1:0] link_state;
    logic link_u0;
    logic pll_off;
    logic lfps_req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lpu_ctrl_st_t;

  localparam logic [lpu_pkg::DIV_W-1:0] DIV_LAST = lpu_pkg::DIV_W'(lpu_pkg::TICK_CYC - 1);

  if (lpu_pkg::TICK_CYC > (1 << lpu_pkg::DIV_W))
  begin : g_chk
    $error("lpu_ctrl: divider too narrow for tick");
  end

  lpu_ctrl_st_t q;
  lpu_ctrl_st_t d;
  logic [7:0] u1_cnt;
  logic u1_exp;
  logic u2_exp;
  logic u1_restart;
  logic u2_restart;
  logic [7:0] u1_limit;
  logic [7:0] u2_limit;
  logic u1_to_ok;
  logic u2_to_ok;

  // Timeouts 00 and FF disable the timers and downstream initiation
  assign u1_to_ok = (q.u1_to != 8'h00) && (q.u1_to != lpu_pkg::TIMEOUT_OFF);
  assign u2_to_ok = (q.u2_to != 8'h00) && (q.u2_to != lpu_pkg::TIMEOUT_OFF);
  assign u1_limit = u1_to_ok ? q.u1_to : 8'h00;
  assign u2_limit = u2_to_ok ? q.u2_to : 8'h00;

  // Any traffic or leaving U0, a reject included, restarts the count
  assign u1_restart = (q.st != lpu_pkg::ST_U0) || link_activity || rx_valid
    || q.tx_valid;
  // U2 timer runs only while the link sits in U1
  assign u2_restart = (q.st != lpu_pkg::ST_U1);

  lpu_timer #(.CNT_W(8)) u_u1_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(q.tick),
    .restart(u1_restart),
    .limit(u1_limit),
    .count(u1_cnt),
    .expired(u1_exp)
  );

  lpu_timer #(.CNT_W(8)) u_u2_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(q.tick),
    .restart(u2_restart),
    .limit(u2_limit),
    .count(),
    .expired(u2_exp)
  );

  // Next-state logic: divider, link state machine, then APB
  always_comb
  begin
    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic rx_go1;
    logic rx_go3;
    logic rx_acc;
    logic rx_rej;
    logic accept;
    logic dn_init;
    logic up_init;
    acc = psel && penable;
    wr = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    rx_go1 = rx_valid && (rx_cmd == lpu_pkg::CMD_GO_U1);
    rx_go3 = rx_valid && (rx_cmd == lpu_pkg::CMD_GO_U3);
    rx_acc = rx_valid && (rx_cmd == lpu_pkg::CMD_ACCEPT);
    rx_rej = rx_valid && (rx_cmd == lpu_pkg::CMD_REJECT);
    // Downstream rejects when not accepting; both reject if busy soon
    accept = !tx_pending && (!q.is_dn || q.acc_en);
    dn_init = q.is_dn && u1_exp && u1_to_ok;
    up_init = !q.is_dn && q.u1_en && u1_policy_req && !tx_pending;
    d = q;
    d.tx_valid = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // Timer tick divider
    d.tick = (q.div == DIV_LAST);
    d.div = d.tick ? '0 : q.div + 1'b1;

    // Link power state machine
    case (q.st)
      lpu_pkg::ST_U0:
      begin
        d.u3_exit = 1'b0;
        if (q.u3_req && q.is_dn)
        begin
          // Downstream suspend only ever starts from a software command
          d.u3_req = 1'b0;
          d.tx_valid = 1'b1;
          d.tx_cmd = lpu_pkg::CMD_GO_U3;
          d.wait_u3 = 1'b1;
          d.st = lpu_pkg::ST_WAIT;
        end
        else if (rx_go3 && !q.is_dn)
        begin
          // Suspend request cannot be refused
          d.tx_valid = 1'b1;
          d.tx_cmd = lpu_pkg::CMD_ACCEPT;
          d.st = lpu_pkg::ST_U3;
        end
        else if (rx_go1)
        begin
          d.tx_valid = 1'b1;
          d.tx_cmd = accept ? lpu_pkg::CMD_ACCEPT : lpu_pkg::CMD_REJECT;
          d.st = accept ? lpu_pkg::ST_U1 : lpu_pkg::ST_U0;
        end
        else if (dn_init || up_init)
        begin
          // Either end may start the handshake
          d.tx_valid = 1'b1;
          d.tx_cmd = lpu_pkg::CMD_GO_U1;
          d.wait_u3 = 1'b0;
          d.st = lpu_pkg::ST_WAIT;
        end
      end
      lpu_pkg::ST_WAIT:
      begin
        if (rx_acc)
          d.st = q.wait_u3 ? lpu_pkg::ST_U3 : lpu_pkg::ST_U1;
        else if (rx_rej)
        begin
          // Reject is not a completed request; timer restarts
          d.st = lpu_pkg::ST_U0;
          d.rej_cnt = q.rej_cnt + 8'h01;
        end
      end
      lpu_pkg::ST_U1:
      begin
        if (tx_pending || rx_lfps)
          d.st = lpu_pkg::ST_EXIT;
        else if (u2_exp)
          d.st = lpu_pkg::ST_U2;
      end
      lpu_pkg::ST_U2:
      begin
        if (tx_pending || rx_lfps)
          d.st = lpu_pkg::ST_EXIT;
      end
      lpu_pkg::ST_U3:
      begin
        // Host software exit on downstream, remote wakeup upstream
        if ((q.u3_exit && q.is_dn) || (remote_wake && !q.is_dn) || rx_lfps)
        begin
          d.u3_exit = 1'b0;
          d.st = lpu_pkg::ST_EXIT;
        end
      end
      lpu_pkg::ST_EXIT:
      begin
        if (train_done)
          d.st = lpu_pkg::ST_U0;
      end
      default:
      begin
        d.st = lpu_pkg::ST_U0;
      end
    endcase

    // Registered status outputs follow the next state
    case (d.st)
      lpu_pkg::ST_U1: d.link_state = lpu_pkg::LS_U1;
      lpu_pkg::ST_U2: d.link_state = lpu_pkg::LS_U2;
      lpu_pkg::ST_U3: d.link_state = lpu_pkg::LS_U3;
      lpu_pkg::ST_EXIT: d.link_state = q.link_state;
      default: d.link_state = lpu_pkg::LS_U0;
    endcase
    d.link_u0 = (d.st == lpu_pkg::ST_U0) || (d.st == lpu_pkg::ST_WAIT);
    d.pll_off = (d.st == lpu_pkg::ST_U2);
    d.lfps_req = (d.st == lpu_pkg::ST_EXIT) && (q.st != lpu_pkg::ST_EXIT || !train_done);

    // APB read mux, one wait state
    case (paddr)
      lpu_pkg::OFS_CTRL:
      begin
        hit = 1'b1;
        rd[lpu_pkg::CTRL_IS_DN] = q.is_dn;
        rd[lpu_pkg::CTRL_U1_EN] = q.u1_en;
        rd[lpu_pkg::CTRL_ACC_EN] = q.acc_en;
        rd[lpu_pkg::CTRL_GO_U3] = q.u3_req;
        rd[lpu_pkg::CTRL_EXIT_U3] = q.u3_exit;
      end
      lpu_pkg::OFS_U1_TIMEOUT:
      begin
        hit = 1'b1;
        rd[7:0] = q.u1_to;
      end
      lpu_pkg::OFS_U2_TIMEOUT:
      begin
        hit = 1'b1;
        rd[7:0] = q.u2_to;
      end
      lpu_pkg::OFS_STATUS:
      begin
        hit = 1'b1;
        rd[lpu_pkg::STAT_LS_LO +: 2] = q.link_state;
        rd[lpu_pkg::STAT_WAIT] = (q.st == lpu_pkg::ST_WAIT);
        rd[lpu_pkg::STAT_REJ_LO +: 8] = q.rej_cnt;
      end
      default: hit = 1'b0;
    endcase
    if (acc && !q.pready)
    begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
    end
    wr = acc && q.pready && pwrite && !q.pslverr;
    // Writes come last so a software set wins over a same-cycle clear
    if (wr)
    begin
      case (paddr)
        lpu_pkg::OFS_CTRL:
        begin
          d.is_dn = pwdata[lpu_pkg::CTRL_IS_DN];
          d.u1_en = pwdata[lpu_pkg::CTRL_U1_EN];
          d.acc_en = pwdata[lpu_pkg::CTRL_ACC_EN];
          // Writing zero keeps a same-cycle hardware clear
          d.u3_req = d.u3_req | pwdata[lpu_pkg::CTRL_GO_U3];
          d.u3_exit = d.u3_exit | pwdata[lpu_pkg::CTRL_EXIT_U3];
        end
        lpu_pkg::OFS_U1_TIMEOUT: d.u1_to = pwdata[7:0];
        lpu_pkg::OFS_U2_TIMEOUT: d.u2_to = pwdata[7:0];
        default: d.u1_to = q.u1_to;
      endcase
    end
  end

  // State register; timeouts start disabled so nothing initiates early
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.st <= lpu_pkg::ST_U0;
      q.u1_to <= lpu_pkg::U1_TIMEOUT_RST;
      q.u2_to <= lpu_pkg::U2_TIMEOUT_RST;
      q.link_u0 <= 1'b1;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_valid = q.tx_valid;
  assign tx_cmd = q.tx_cmd;
  assign link_state = q.link_state;
  assign link_u0 = q.link_u0;
  assign pll_off = q.pll_off;
  assign lfps_req = q.lfps_req;

  // Checks on the handshake and state progression
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_req_sent;
    q.tx_valid && (q.tx_cmd == lpu_pkg::CMD_GO_U1);
  endsequence

  sequence s_rx_u1_in_u0;
    (q.st == lpu_pkg::ST_U0) && rx_valid && (rx_cmd == lpu_pkg::CMD_GO_U1)
      && !(q.u3_req && q.is_dn) && !(rx_cmd == lpu_pkg::CMD_GO_U3);
  endsequence

  a_dn_reject_dis: assert property (s_rx_u1_in_u0 and (q.is_dn && !q.acc_en) |=>
    q.tx_valid && (q.tx_cmd == lpu_pkg::CMD_REJECT) && (q.st == lpu_pkg::ST_U0))
    else $error("disabled downstream did not reject");

  a_busy_reject: assert property (s_rx_u1_in_u0 and tx_pending |=>
    q.tx_cmd == lpu_pkg::CMD_REJECT)
    else $error("busy port did not reject");

  a_up_answers: assert property (s_rx_u1_in_u0 and !q.is_dn |=> q.tx_valid)
    else $error("upstream did not answer");

  // Partner answer may come many cycles after the request
  sequence s_acc_rx;
    (q.st == lpu_pkg::ST_WAIT) && !q.wait_u3 && rx_valid && (rx_cmd == lpu_pkg::CMD_ACCEPT);
  endsequence

  a_accept_u1: assert property (s_req_sent ##[1:20] s_acc_rx |=>
    (q.st == lpu_pkg::ST_U1) ##1 (q.link_state == lpu_pkg::LS_U1))
    else $error("accept did not enter U1");

  a_reject_restart: assert property ((q.st == lpu_pkg::ST_WAIT) && rx_valid
    && (rx_cmd == lpu_pkg::CMD_REJECT) |=> (q.st == lpu_pkg::ST_U0) && (u1_cnt == 8'h00))
    else $error("reject did not restart timer");

  a_dn_req_gate: assert property (s_req_sent and q.is_dn |->
    $past(u1_to_ok) && $past(u1_exp))
    else $error("downstream request without valid timeout");

  a_up_req_gate: assert property (s_req_sent and !q.is_dn |-> $past(q.u1_en))
    else $error("upstream request while not enabled");

  a_u3_sw_only: assert property ((q.st != lpu_pkg::ST_U3) ##1 (q.st == lpu_pkg::ST_U3)
    |-> $past(q.wait_u3) || $past(rx_valid && (rx_cmd == lpu_pkg::CMD_GO_U3)))
    else $error("U3 entered without command");

  a_u2_from_u1: assert property ((q.st == lpu_pkg::ST_U1) && u2_exp && !tx_pending
    && !rx_lfps |=> (q.st == lpu_pkg::ST_U2) ##1 q.pll_off)
    else $error("U2 timer expiry did not enter U2");

  a_exit_train: assert property ((q.st == lpu_pkg::ST_U1) && rx_lfps |=>
    (q.st == lpu_pkg::ST_EXIT) ##1 q.lfps_req || (q.st == lpu_pkg::ST_U0))
    else $error("U1 exit did not start signalling");

  a_traffic_u0: assert property (q.link_u0 |-> (q.link_state == lpu_pkg::LS_U0))
    else $error("traffic allowed outside U0");

endmodule

// ==== testbench/lpu_partner.sv ====
// Link partner port model that answers and issues link commands
`timescale 1ns/1ps
module lpu_partner (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic tx_valid, // Command from the port
  input wire logic [1:0] tx_cmd, // Its code
  input wire logic reject, // Refuse every go-U1 seen while high
  input wire logic [3:0] dly, // Extra answer delay in cycles
  input wire logic send_req, // Pulse, issue send_cmd
  input wire logic [1:0] send_cmd, // Command to issue
  output logic rx_valid, // Command to the port
  output logic [1:0] rx_cmd // Its code
);
  logic [4:0] wait_q;
  logic [1:0] ans_q;

  // One request outstanding; code lines toggle between pulses so stale codes never match
  always_ff @(posedge core_clk)
  begin
    rx_valid <= 1'b0;
    rx_cmd <= ~rx_cmd;
    if (!resetn)
    begin
      wait_q <= 5'h00;
      rx_cmd <= 2'h0;
    end
    else if (wait_q == 5'h01)
    begin
      wait_q <= 5'h00;
      rx_valid <= 1'b1;
      rx_cmd <= ans_q;
    end
    else if (wait_q != 5'h00)
      wait_q <= wait_q - 5'h01;
    else if (tx_valid && tx_cmd inside {lpu_pkg::CMD_GO_U1, lpu_pkg::CMD_GO_U3})
    begin
      wait_q <= {1'b0, dly} + 5'h01;
      // Suspend entry is never refused
      ans_q <= (reject && tx_cmd == lpu_pkg::CMD_GO_U1) ?
        lpu_pkg::CMD_REJECT : lpu_pkg::CMD_ACCEPT;
    end
    else if (send_req)
    begin
      rx_valid <= 1'b1;
      rx_cmd <= send_cmd;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the link power U1 entry controller
`timescale 1ns/1ps
module tb;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, err, f;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic rx_valid, tx_valid, link_activity, tx_pending, u1_policy_req, rx_lfps;
  logic remote_wake, train_done, link_u0, pll_off, lfps_req, reject, send_req;
  logic [1:0] rx_cmd, tx_cmd, link_state, send_cmd;
  logic [3:0] dly;
  logic [7:0] tos [2] = '{8'h00, 8'hFF};
  int failures, checks_done, cycles, i;

  lpu_ctrl i_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_cmd(rx_cmd), .tx_valid(tx_valid),
    .tx_cmd(tx_cmd), .link_activity(link_activity), .tx_pending(tx_pending),
    .u1_policy_req(u1_policy_req), .rx_lfps(rx_lfps), .remote_wake(remote_wake),
    .train_done(train_done), .link_state(link_state), .link_u0(link_u0),
    .pll_off(pll_off), .lfps_req(lfps_req));

  lpu_partner i_partner (.core_clk(core_clk), .resetn(resetn), .tx_valid(tx_valid),
    .tx_cmd(tx_cmd), .reject(reject), .dly(dly), .send_req(send_req),
    .send_cmd(send_cmd), .rx_valid(rx_valid), .rx_cmd(rx_cmd));

  // Clock, 50 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    // Idle edge first, so chained calls never drive psel twice in one step
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_q, err);
  endtask

  task automatic wait_tx(input logic [1:0] c, input int m, output logic g);
    g = 1'b0;
    for (int n = 0; n < m && !g; n++)
    begin
      @(posedge core_clk);
      g = (tx_valid === 1'b1 && tx_cmd === c);
    end
  endtask

  task automatic wait_ls(input logic [1:0] s, input int m);
    for (int n = 0; n < m && link_state !== s; n++)
      @(posedge core_clk);
    chk("link_state", {30'h0, s}, {30'h0, link_state});
  endtask

  task automatic psend(input logic [1:0] c);
    send_cmd <= c;
    send_req <= 1'b1;
    @(posedge core_clk);
    send_req <= 1'b0;
  endtask

  // Exit signalling then training back to the active state
  task automatic leave();
    for (int n = 0; n < 8 && lfps_req !== 1'b1; n++)
      @(posedge core_clk);
    chk("lfps_req", 32'h1, {31'h0, lfps_req});
    rx_lfps <= 1'b0;
    remote_wake <= 1'b0;
    train_done <= 1'b1;
    @(posedge core_clk);
    train_done <= 1'b0;
    wait_ls(lpu_pkg::LS_U0, 8);
    chk("link_u0", 32'h1, {31'h0, link_u0});
  endtask

  // Hang guard, far above the several hundred cycles the sequence needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  initial
  begin
    {resetn, psel, penable, pwrite, link_activity, tx_pending, u1_policy_req} = '0;
    {rx_lfps, remote_wake, train_done, reject, send_req} = '0;
    {paddr, pwdata, send_cmd} = '0;
    dly = 4'h3;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, rd_q, err);
      chk("reset read", 32'h0, rd_q);
    end
    apb(1'b0, 8'h10, 32'h0, rd_q, err);
    chk("unmapped pslverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd_q);
    // Parameters first, then initiation enabled
    wr(lpu_pkg::OFS_U2_TIMEOUT, 32'h02);
    wr(lpu_pkg::OFS_CTRL, 32'h05);
    for (i = 0; i < 2; i++)
    begin
      wr(lpu_pkg::OFS_U1_TIMEOUT, {24'h0, tos[i]});
      wait_tx(lpu_pkg::CMD_GO_U1, 200, f);
      chk("request with timer off", 32'h0, {31'h0, f});
    end
    reject <= 1'b1;
    link_activity <= 1'b1;
    wr(lpu_pkg::OFS_U1_TIMEOUT, 32'h01);
    wait_tx(lpu_pkg::CMD_GO_U1, 100, f);
    chk("request under traffic", 32'h0, {31'h0, f});
    link_activity <= 1'b0;
    wait_tx(lpu_pkg::CMD_GO_U1, 60, f);
    chk("timer request", 32'h1, {31'h0, f});
    reject <= 1'b0;
    wait_tx(lpu_pkg::CMD_GO_U1, 80, f);
    chk("request after reject", 32'h1, {31'h0, f});
    wait_ls(lpu_pkg::LS_U1, 10);
    apb(1'b0, lpu_pkg::OFS_STATUS, 32'h0, rd_q, err);
    chk("status", 32'h101, rd_q);
    chk("link_u0 in U1", 32'h0, {31'h0, link_u0});
    wait_ls(lpu_pkg::LS_U2, 80);
    chk("pll_off", 32'h1, {31'h0, pll_off});
    wr(lpu_pkg::OFS_U1_TIMEOUT, 32'h00);
    rx_lfps <= 1'b1;
    leave();
    wr(lpu_pkg::OFS_CTRL, 32'h0D);
    wait_tx(lpu_pkg::CMD_GO_U3, 20, f);
    chk("suspend request", 32'h1, {31'h0, f});
    wait_ls(lpu_pkg::LS_U3, 10);
    wr(lpu_pkg::OFS_CTRL, 32'h15);
    leave();
    wr(lpu_pkg::OFS_CTRL, 32'h01);
    psend(lpu_pkg::CMD_GO_U1);
    wait_tx(lpu_pkg::CMD_REJECT, 4, f);
    chk("refused while not accepting", 32'h1, {31'h0, f});
    // Upstream side
    wr(lpu_pkg::OFS_CTRL, 32'h00);
    u1_policy_req <= 1'b1;
    wait_tx(lpu_pkg::CMD_GO_U1, 60, f);
    chk("request while disabled", 32'h0, {31'h0, f});
    psend(lpu_pkg::CMD_GO_U1);
    wait_tx(lpu_pkg::CMD_ACCEPT, 4, f);
    chk("answer accept", 32'h1, {31'h0, f});
    wait_ls(lpu_pkg::LS_U1, 4);
    tx_pending <= 1'b1;
    leave();
    psend(lpu_pkg::CMD_GO_U1);
    wait_tx(lpu_pkg::CMD_REJECT, 4, f);
    chk("answer reject", 32'h1, {31'h0, f});
    tx_pending <= 1'b0;
    dly <= 4'h0;
    wr(lpu_pkg::OFS_CTRL, 32'h02);
    wait_tx(lpu_pkg::CMD_GO_U1, 60, f);
    chk("policy request", 32'h1, {31'h0, f});
    wait_ls(lpu_pkg::LS_U1, 10);
    u1_policy_req <= 1'b0;
    rx_lfps <= 1'b1;
    leave();
    psend(lpu_pkg::CMD_GO_U3);
    wait_ls(lpu_pkg::LS_U3, 10);
    remote_wake <= 1'b1;
    leave();
    finish_test();
  end
endmodule
